// ### verilog/sdm_ctrl.sv
// Memory controller core: register port, init commands, refresh, low-power modes.
// Assumes a same-clock register master and access requester; memory clock is a pin.
`timescale 1ns/100ps
module sdm_ctrl
	import sdm_pkg::*;
#(
	parameter int BANK0_BIT = 22,
	parameter int BANK1_BIT = 23
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        memory_clock,
	input  wire logic        acc_req,
	input  wire sdm_acc_t    acc,
	output logic             acc_ack,
	output sdm_mem_pins_t    mem
);
	logic        tick;
	logic [3:0]  ch_en, ch_flash;
	logic [7:0]  ref_period, ref_cnt;
	logic [1:0]  trcd, trp;
	logic        auto_powerdown_enable;
	logic        cmd_pend;
	logic [2:0]  cmd_code;
	logic [14:0] cmd_oper;
	logic [3:0]  next_ch_en, next_ch_flash;
	logic [7:0]  next_ref_period, next_ref_cnt;
	logic [1:0]  next_trcd, next_trp;
	logic        next_auto_powerdown_enable;
	logic        next_cmd_pend;
	logic [2:0]  next_cmd_code;
	logic [14:0] next_cmd_oper;
	logic [31:0] next_reg_rdata;
	logic [7:0]  ref_tmr, next_ref_tmr;
	logic        ref_pend, next_ref_pend;
	sdm_state_t  st, next_st;
	logic [3:0]  wake_cnt, next_wake_cnt;
	logic [1:0]  wait_cnt, next_wait_cnt;
	sdm_acc_t    acc_q, next_acc_q;
	sdm_mem_pins_t next_mem;
	logic        next_acc_ack;
	logic        ref_issue, cmd_take, exit_req, gen_run;

	sdm_edge_sync u_clk_sync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.din     (memory_clock),
		.rise    (tick)
	);

	assign ref_issue = tick && st == ST_IDLE && ref_pend;                 // RL7
	assign cmd_take  = tick && st == ST_IDLE && !ref_pend && cmd_pend;
	assign exit_req  = ref_pend || cmd_pend || acc_req;                   // RL11
	assign gen_run   = st != ST_PD && st != ST_SR;                        // RL8

	// Register file
	always_comb begin
		next_ch_en                 = ch_en;
		next_ch_flash              = ch_flash;
		next_ref_period            = ref_period;
		next_ref_cnt               = ref_cnt;
		next_trcd                  = trcd;
		next_trp                   = trp;
		next_auto_powerdown_enable = auto_powerdown_enable;
		next_cmd_pend              = cmd_pend;
		next_cmd_code              = cmd_code;
		next_cmd_oper              = cmd_oper;
		next_reg_rdata             = 32'h0000_0000;
		if (ref_issue && ref_cnt != 8'h00)
			next_ref_cnt = ref_cnt - 8'h01;                                 // RL6
		if (cmd_take)
			next_cmd_pend = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CHAN0, OFS_CHAN1, OFS_CHAN2, OFS_CHAN3: begin
					next_ch_en[reg_addr[3:2]]    = reg_wdata[CH_EN_BIT];
					next_ch_flash[reg_addr[3:2]] = reg_wdata[CH_FLASH_BIT];
				end
				OFS_TIMING: begin
					// One setting for every channel
					next_ref_period            = reg_wdata[TM_PERIOD_LSB +: 8];  // RL4
					next_ref_cnt               = reg_wdata[TM_COUNT_LSB +: 8];
					next_trcd                  = reg_wdata[TM_RCD_LSB +: 2];
					next_trp                   = reg_wdata[TM_RP_LSB +: 2];
					next_auto_powerdown_enable = reg_wdata[TM_AUTO_POWERDOWN_ENABLE_BIT];
				end
				OFS_COMMAND: begin
					// New command wins over the clear of the old one
					next_cmd_pend = 1'b1;                                     // RL3
					next_cmd_code = reg_wdata[CMD_CODE_LSB +: 3];
					next_cmd_oper = reg_wdata[CMD_OPER_LSB +: 15];
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_CHAN0, OFS_CHAN1, OFS_CHAN2, OFS_CHAN3: begin
					next_reg_rdata[CH_EN_BIT]    = ch_en[reg_addr[3:2]];
					next_reg_rdata[CH_FLASH_BIT] = ch_flash[reg_addr[3:2]];
				end
				OFS_TIMING: begin
					next_reg_rdata[TM_PERIOD_LSB +: 8] = ref_period;
					next_reg_rdata[TM_COUNT_LSB +: 8]  = ref_cnt;
					next_reg_rdata[TM_RCD_LSB +: 2]    = trcd;
					next_reg_rdata[TM_RP_LSB +: 2]     = trp;
					next_reg_rdata[TM_AUTO_POWERDOWN_ENABLE_BIT]        = auto_powerdown_enable;
				end
				OFS_COMMAND: begin
					next_reg_rdata[CMD_CODE_LSB +: 3]  = cmd_code;
					next_reg_rdata[CMD_OPER_LSB +: 15] = cmd_oper;
				end
				OFS_STATUS: begin
					next_reg_rdata[ST_CMD_PEND_BIT] = cmd_pend;
					next_reg_rdata[ST_REF_PEND_BIT] = ref_pend;
					next_reg_rdata[ST_PD_BIT]       = st == ST_PD;
					next_reg_rdata[ST_SR_BIT]       = st == ST_SR;
					next_reg_rdata[ST_APD_BIT]      = st == ST_APD;
					next_reg_rdata[ST_BUSY_BIT]     = st != ST_IDLE;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ch_en                 <= CH_EN_RST;
			ch_flash              <= CH_FLASH_RST;
			ref_period            <= PERIOD_RST;
			ref_cnt               <= COUNT_RST;
			trcd                  <= RCD_RST;
			trp                   <= RP_RST;
			auto_powerdown_enable <= AUTO_POWERDOWN_ENABLE_RST;
			cmd_pend              <= 1'b0;
			cmd_code              <= CMD_NOP;
			cmd_oper              <= 15'h0000;
			reg_rdata             <= 32'h0000_0000;
		end else begin
			ch_en                 <= next_ch_en;
			ch_flash              <= next_ch_flash;
			ref_period            <= next_ref_period;
			ref_cnt               <= next_ref_cnt;
			trcd                  <= next_trcd;
			trp                   <= next_trp;
			auto_powerdown_enable <= next_auto_powerdown_enable;
			cmd_pend              <= next_cmd_pend;
			cmd_code              <= next_cmd_code;
			cmd_oper              <= next_cmd_oper;
			reg_rdata             <= next_reg_rdata;
		end
	end

	// Refresh generator; frozen in command-entered low power, alive in auto power-down
	always_comb begin
		next_ref_tmr  = ref_tmr;
		next_ref_pend = ref_pend;
		if (ref_issue)
			next_ref_pend = 1'b0;
		if (tick && gen_run) begin                                          // RL8 RL10
			if (ref_tmr == 8'h00) begin
				next_ref_tmr  = ref_period;
				next_ref_pend = 1'b1;
			end else begin
				next_ref_tmr = ref_tmr - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ref_tmr  <= PERIOD_RST;
			ref_pend <= 1'b0;
		end else begin
			ref_tmr  <= next_ref_tmr;
			ref_pend <= next_ref_pend;
		end
	end

	// Sequencer: pins change only on a memory clock tick
	always_comb begin
		next_st       = st;
		next_wake_cnt = wake_cnt;
		next_wait_cnt = wait_cnt;
		next_acc_q    = acc_q;
		next_mem      = mem;
		next_acc_ack  = 1'b0;
		if (tick) begin
			next_mem.cs_n  = 4'hF;
			next_mem.rcw_n = PIN_NOP;
			case (st)
				ST_IDLE: begin
					if (ref_pend) begin
						next_mem.cs_n  = ~ch_en;                                // RL7
						next_mem.rcw_n = PIN_REF;
						next_wait_cnt  = trp;
						next_st        = ST_WAIT;
					end else if (cmd_pend) begin
						next_wait_cnt = trp;
						next_st       = ST_WAIT;
						case (cmd_code)
							CMD_PRE_ALL: begin
								next_mem.cs_n              = ~ch_en;
								next_mem.rcw_n             = PIN_PRE;
								next_mem.row_col_bit10_pin = 1'b1;
							end
							CMD_MRS_SDRAM, CMD_MRS_FLASH: begin
								// Mode set goes to one memory kind at a time
								next_mem.cs_n = (cmd_code == CMD_MRS_FLASH) ?
									~(ch_en & ch_flash) : ~(ch_en & ~ch_flash);       // RL3
								next_mem.rcw_n = PIN_MRS;
								{next_mem.addr_hi, next_mem.row_col_bit10_pin,
									next_mem.addr_lo} = cmd_oper;
							end
							CMD_POWER_DOWN: begin
								// No refresh here, so DRAM contents decay
								next_mem.cke = 1'b0;                                // RL8 RL14
								next_st      = ST_PD;
							end
							CMD_SELF_REF: begin
								next_mem.cke   = 1'b0;                              // RL8 RL14
								next_mem.cs_n  = ~ch_en;
								next_mem.rcw_n = PIN_REF;
								next_st        = ST_SR;
							end
							default: next_st = ST_IDLE;                           // RL9
						endcase
					end else if (acc_req) begin
						next_acc_q     = acc;
						next_mem.cs_n  = ~(4'h1 << acc.chan);
						next_mem.rcw_n = PIN_ACT;
						next_mem.addr_hi = {acc.addr[BANK0_BIT], acc.addr[BANK1_BIT],
							acc.addr[PA_HI_MSB:PA_HI_LSB]};                      // RL1
						next_mem.row_col_bit10_pin = acc.addr[PA_ROW10];
						next_mem.addr_lo = acc.addr[PA_ROW_MSB:PA_ROW_LSB];     // RL1
						next_wait_cnt  = trcd;
						next_st        = ST_RCD;
					end else if (auto_powerdown_enable) begin
						next_mem.cke = 1'b0;                                    // RL10 RL16
						next_st      = ST_APD;
					end
				end
				ST_RCD: begin
					if (wait_cnt == 2'h0) begin
						next_mem.cs_n  = ~(4'h1 << acc_q.chan);
						next_mem.rcw_n = acc_q.write ? PIN_WRITE : PIN_READ;
						next_mem.row_col_bit10_pin = 1'b1;                       // RL2
						next_mem.addr_lo = {acc_q.addr[PA_CX_MSB:PA_CX_LSB],
							acc_q.addr[PA_COL_MSB:PA_COL_LSB]};                  // RL2
						next_acc_ack  = 1'b1;
						next_wait_cnt = trp;
						next_st       = ST_WAIT;
					end else begin
						next_wait_cnt = wait_cnt - 2'h1;
					end
				end
				ST_WAIT: begin
					// Cycle completes before any low-power entry
					if (wait_cnt == 2'h0)
						next_st = ST_IDLE;                                      // RL16
					else
						next_wait_cnt = wait_cnt - 2'h1;
				end
				ST_PD, ST_SR: begin
					if (exit_req) begin
						next_mem.cke  = 1'b1;                                   // RL11 RL9
						next_wake_cnt = WAKE_TICKS;                             // RL12
						next_st       = ST_WAKE;
					end
				end
				ST_APD: begin
					// Straight back to idle: only the cke rise costs a clock
					if (exit_req) begin
						next_mem.cke = 1'b1;                                    // RL13
						next_st      = ST_IDLE;
					end
				end
				ST_WAKE: begin
					if (wake_cnt <= 4'h1)
						next_st = ST_IDLE;                                      // RL12
					else
						next_wake_cnt = wake_cnt - 4'h1;
				end
				default: next_st = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st       <= ST_IDLE;
			wake_cnt <= 4'h0;
			wait_cnt <= 2'h0;
			acc_q    <= '0;
			mem      <= PINS_RST;
			acc_ack  <= 1'b0;
		end else begin
			st       <= next_st;
			wake_cnt <= next_wake_cnt;
			wait_cnt <= next_wait_cnt;
			acc_q    <= next_acc_q;
			mem      <= next_mem;
			acc_ack  <= next_acc_ack;
		end
	end

	a_row_mapping: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL1
		(tick && st == ST_IDLE && !ref_pend && !cmd_pend && acc_req) |=>
		(mem.rcw_n == PIN_ACT && mem.addr_lo == acc_q.addr[18:9] &&
		 mem.addr_hi[19] == acc_q.addr[BANK0_BIT]))
		else $error("row address mapping wrong");
	a_col_mapping: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL2
		acc_ack |-> (mem.row_col_bit10_pin && mem.addr_lo[12:5] == acc_q.addr[8:1] &&
		 mem.addr_lo[14:13] == acc_q.addr[23:22]))
		else $error("column address mapping wrong");
	a_mrs_split: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL3
		(cmd_take && cmd_code == CMD_MRS_SDRAM) |=> ((~mem.cs_n & ch_flash) == 4'h0))
		else $error("sdram mode set reached a flash channel");
	a_ref_count: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL6
		(ref_issue && ref_cnt != 8'h00 && !reg_wr) |=> ref_cnt == $past(ref_cnt) - 8'h01)
		else $error("refresh count did not step down");
	a_ref_priority: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL7
		(tick && st == ST_IDLE && ref_pend) |=> (mem.rcw_n == PIN_REF && st == ST_WAIT))
		else $error("refresh lost priority");
	a_gen_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL8
		(st == ST_SR || st == ST_PD) ##1 (st == ST_SR || st == ST_PD) |-> $stable(ref_tmr))
		else $error("refresh generator ran in low power");
	a_apd_refresh: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL10
		(st == ST_APD && tick && ref_tmr != 8'h00) |=> ref_tmr == $past(ref_tmr) - 8'h01)
		else $error("refresh generator stopped in auto power-down");
	a_wake_exit: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL11
		(tick && st == ST_SR && exit_req) |=> (st == ST_WAKE && mem.cke))
		else $error("request did not wake memory");
	a_wake_ten: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL12
		(tick && st == ST_PD && exit_req) |=> (wake_cnt == 4'hA && st == ST_WAKE))
		else $error("wake delay not ten clocks");
	a_apd_one: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL13
		(tick && st == ST_APD && exit_req) |=> (st == ST_IDLE && mem.cke))
		else $error("auto power-down exit latency wrong");
	a_finish_first: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL16
		(st == ST_RCD || st == ST_WAIT) |=> !(st == ST_PD || st == ST_SR || st == ST_APD))
		else $error("low power entered mid cycle");
endmodule : sdm_ctrl

// ### verilog/sdm_pkg.sv
// Constants, field layouts and carrier types of the memory controller block.
// Assumes one system clock; memory clock arrives as a sampled input pin.
// Function
// RL1: Bank selects on pins 19/18, row bits 18:9.
// RL2: Column bits 8:1 on pins 12:5, bit10 precharge.
// RL3: Command register issues init cycles; separate mode-set.
// RL4: One timing setting serves all channels.
// RL5: Software follows the documented initialization order.
// RL6: Refresh count decrements once per refresh.
// RL7: Pending refresh beats every other request.
// RL8: Power-down/self-refresh commands stop refresh generator.
// RL9: Normal-mode command returns memory to operation.
// RL10: Auto power-down when idle; refresh keeps running.
// RL11: Any request wakes memory, then gets served.
// RL12: Ten memory clocks after command-mode wakeup.
// RL13: Auto power-down adds exactly one clock latency.
// RL14: Self-refresh keeps data; power-down loses it.
// RL15: Flash deep power-down needs software re-initialization.
// RL16: Running cycle finishes before any low-power entry.
package sdm_pkg;
	localparam int          REG_AW          = 8;
	localparam logic [7:0]  OFS_CHAN0       = 8'h00;
	localparam logic [7:0]  OFS_CHAN1       = 8'h04;
	localparam logic [7:0]  OFS_CHAN2       = 8'h08;
	localparam logic [7:0]  OFS_CHAN3       = 8'h0C;
	localparam logic [7:0]  OFS_TIMING      = 8'h20;
	localparam logic [7:0]  OFS_COMMAND     = 8'h2C;
	localparam logic [7:0]  OFS_STATUS      = 8'h30;
	// Channel control fields
	localparam int          CH_EN_BIT       = 0;
	localparam int          CH_FLASH_BIT    = 1;
	localparam logic [3:0]  CH_EN_RST       = 4'h0;
	localparam logic [3:0]  CH_FLASH_RST    = 4'h0;
	// Timing fields
	localparam int          TM_PERIOD_LSB   = 0;
	localparam int          TM_COUNT_LSB    = 8;
	localparam int          TM_RCD_LSB      = 16;
	localparam int          TM_RP_LSB       = 18;
	localparam int          TM_AUTO_POWERDOWN_ENABLE_BIT     = 20;
	localparam logic [7:0]  PERIOD_RST      = 8'h40;
	localparam logic [7:0]  COUNT_RST       = 8'h00;
	localparam logic [1:0]  RCD_RST         = 2'h1;
	localparam logic [1:0]  RP_RST          = 2'h1;
	localparam logic        AUTO_POWERDOWN_ENABLE_RST        = 1'b0;
	// Command fields and codes
	localparam int          CMD_CODE_LSB    = 0;
	localparam int          CMD_OPER_LSB    = 16;
	localparam logic [2:0]  CMD_NOP         = 3'h0;
	localparam logic [2:0]  CMD_PRE_ALL     = 3'h1;
	localparam logic [2:0]  CMD_MRS_SDRAM   = 3'h2;
	localparam logic [2:0]  CMD_MRS_FLASH   = 3'h3;
	localparam logic [2:0]  CMD_POWER_DOWN  = 3'h4;
	localparam logic [2:0]  CMD_SELF_REF    = 3'h5;
	localparam logic [2:0]  CMD_NORMAL      = 3'h6;
	// Status fields
	localparam int          ST_CMD_PEND_BIT = 0;
	localparam int          ST_REF_PEND_BIT = 1;
	localparam int          ST_PD_BIT       = 2;
	localparam int          ST_SR_BIT       = 3;
	localparam int          ST_APD_BIT      = 4;
	localparam int          ST_BUSY_BIT     = 5;
	// Memory clocks waited after a command-entered low-power exit
	localparam logic [3:0]  WAKE_TICKS      = 4'hA;
	// Physical address bit positions
	localparam int          PA_ROW_MSB      = 18;
	localparam int          PA_ROW_LSB      = 9;
	localparam int          PA_COL_MSB      = 8;
	localparam int          PA_COL_LSB      = 1;
	localparam int          PA_HI_MSB       = 21;
	localparam int          PA_HI_LSB       = 20;
	localparam int          PA_ROW10        = 19;
	localparam int          PA_CX_MSB       = 23;
	localparam int          PA_CX_LSB       = 22;
	// Pin command codes {ras_n, cas_n, we_n}
	localparam logic [2:0]  PIN_NOP         = 3'h7;
	localparam logic [2:0]  PIN_ACT         = 3'h3;
	localparam logic [2:0]  PIN_READ        = 3'h5;
	localparam logic [2:0]  PIN_WRITE       = 3'h4;
	localparam logic [2:0]  PIN_PRE         = 3'h2;
	localparam logic [2:0]  PIN_REF         = 3'h1;
	localparam logic [2:0]  PIN_MRS         = 3'h0;

	typedef struct packed {
		logic        cke;
		logic [3:0]  cs_n;
		logic [2:0]  rcw_n;
		logic [19:16] addr_hi;
		logic        row_col_bit10_pin;
		logic [14:5] addr_lo;
	} sdm_mem_pins_t;

	typedef struct packed {
		logic [1:0]  chan;
		logic        write;
		logic [27:0] addr;
	} sdm_acc_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RCD, ST_WAIT, ST_PD, ST_SR, ST_APD, ST_WAKE
	} sdm_state_t;

	localparam sdm_mem_pins_t PINS_RST = '{cke: 1'b1, cs_n: 4'hF, rcw_n: PIN_NOP,
		addr_hi: 4'h0, row_col_bit10_pin: 1'b0, addr_lo: 10'h000};
endpackage : sdm_pkg

// ### verilog/sdm_edge_sync.sv
// Three-stage synchroniser with rising-edge detection for the memory clock pin.
// Assumes the pin is far slower than clk_sys.
`timescale 1ns/100ps
module sdm_edge_sync (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic din,
	output logic      rise
);
	logic [2:0] sh;
	logic       lvl;
	logic [2:0] next_sh;
	logic       next_lvl;
	logic       next_rise;

	always_comb begin
		next_sh   = {sh[1:0], din};
		next_lvl  = lvl;
		next_rise = 1'b0;
		// A level counts only once stages two and three agree
		if (sh[1] == sh[2]) begin
			next_lvl  = sh[2];
			next_rise = sh[2] & ~lvl;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sh   <= 3'h0;
			lvl  <= 1'b0;
			rise <= 1'b0;
		end else begin
			sh   <= next_sh;
			lvl  <= next_lvl;
			rise <= next_rise;
		end
	end
endmodule : sdm_edge_sync

// ### dv/sdm_mem_model.sv
// Behavioural memory device at the pins: makes the memory clock and decodes commands.
// Assumes the controller's pins settle well before the next memory clock rise.
`timescale 1ns/100ps
module sdm_mem_model
	import sdm_pkg::*;
(
	input  wire sdm_mem_pins_t mem,
	output logic               memory_clock,
	output logic [15:0]        ref_cnt,
	output logic [15:0]        pre_cnt,
	output logic [3:0]         cs_seen,
	output logic [14:0]        mrs_a,
	output logic [14:0]        row_a,
	output logic [14:0]        col_a,
	output logic [2:0]         col_op,
	output logic [7:0]         gap,
	output logic               sr_ref
);
	logic        cke_q;
	logic [7:0]  since;
	logic [14:0] a;

	assign a = {mem.addr_hi, mem.row_col_bit10_pin, mem.addr_lo};

	// The memory clock runs free, with a phase unrelated to the system clock
	initial begin
		memory_clock = 1'b0;
		{ref_cnt, pre_cnt, cs_seen, mrs_a, row_a, col_a, col_op, gap, sr_ref} = '0;
		cke_q = 1'b1;
		since = 8'hFF;
		#137;
		forever #400 memory_clock = ~memory_clock;
	end

	always @(posedge memory_clock) begin
		cke_q <= mem.cke;
		// Rises counted since clock enable came back, saturating
		since <= (mem.cke && !cke_q) ? 8'h00 : (since == 8'hFF) ? since : since + 8'h01;
		if (mem.cs_n != 4'hF) begin
			cs_seen <= mem.cs_n;
			case (mem.rcw_n)
				PIN_REF: begin
					// Refresh with clock enable low enters self-refresh; contents kept
					if (mem.cke)
						ref_cnt <= ref_cnt + 16'h0001;
					else
						sr_ref <= 1'b1;
				end
				PIN_PRE: pre_cnt <= pre_cnt + 16'h0001;
				PIN_MRS: mrs_a <= a;
				PIN_ACT: begin
					row_a <= a;
					gap <= since + 8'h01;
				end
				PIN_READ, PIN_WRITE: begin
					col_a  <= a;
					col_op <= mem.rcw_n;
				end
				default: ;
			endcase
		end
	end
endmodule : sdm_mem_model

// ### dv/test_sdm_ctrl.sv
// Self-checking bench for the memory controller core: register tasks and scripted scenarios.
// Assumes the memory model supplies the memory clock and decodes the pin commands.
`timescale 1ns/100ps
module test_sdm_ctrl import sdm_pkg::*; ;
	logic          clk_sys   = 1'b0;
	logic          sys_rst   = 1'b1;
	logic [7:0]    reg_addr  = 8'h00;
	logic [31:0]   reg_wdata = 32'h0;
	logic          reg_wr    = 1'b0;
	logic          reg_rd    = 1'b0;
	logic          acc_req   = 1'b0;
	sdm_acc_t      acc       = '0;
	logic [31:0]   reg_rdata;
	logic          memory_clock;
	logic          acc_ack;
	sdm_mem_pins_t mem;
	logic [15:0]   ref_cnt;
	logic [15:0]   pre_cnt;
	logic [3:0]    cs_seen;
	logic [14:0]   mrs_a;
	logic [14:0]   row_a;
	logic [14:0]   col_a;
	logic [2:0]    col_op;
	logic [7:0]    gap;
	logic          sr_ref;
	logic [31:0]   d;
	logic [15:0]   r0;
	int            error_cnt = 0;
	int            n_tests   = 0;
	int            cyc       = 0;
	int            i;
	logic [14:0]   mrs_op [2] = '{15'h1234, 15'h0567};
	logic [2:0]    mrs_cd [2] = '{CMD_MRS_SDRAM, CMD_MRS_FLASH};
	logic [3:0]    mrs_cs [2] = '{4'hE, 4'hD};

	sdm_ctrl u_sdm_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.memory_clock(memory_clock), .acc_req(acc_req), .acc(acc), .acc_ack(acc_ack),
		.mem(mem));
	sdm_mem_model u_sdm_mem_model (.mem(mem), .memory_clock(memory_clock),
		.ref_cnt(ref_cnt), .pre_cnt(pre_cnt), .cs_seen(cs_seen), .mrs_a(mrs_a),
		.row_a(row_a), .col_a(col_a), .col_op(col_op), .gap(gap), .sr_ref(sr_ref));

	always #50 clk_sys = ~clk_sys;

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// The whole script needs well under a third of this
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just inside it
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic access(input logic [27:0] a, input logic w);
		int k;
		@(posedge clk_sys);
		acc <= '{chan: 2'h0, write: w, addr: a};
		acc_req <= 1'b1;
		for (k = 0; k < 400 && acc_ack !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		chk("acc_ack", {31'h0, acc_ack}, 32'h1);
		@(posedge clk_sys);
		acc_req <= 1'b0;
		tk(24);
		chk("row pins", {17'h0, row_a}, {17'h0, a[22], a[23], a[21:20], a[19], a[18:9]});
		chk("col pins", {24'h0, col_a[7:0]}, {24'h0, a[8:1]});
		chk("col bit10", {31'h0, col_a[10]}, 32'h1);
		chk("col hi", {30'h0, col_a[9:8]}, {30'h0, a[23:22]});
		chk("col op", {29'h0, col_op}, {29'h0, w ? PIN_WRITE : PIN_READ});
		chk("acc cs", {28'h0, cs_seen}, 32'hE);
	endtask : access

	initial begin
		tk(4);
		sys_rst <= 1'b0;
		tk(8);
		rd(OFS_TIMING, d);
		chk("timing reset", d, 32'h0005_0040);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, d);
		chk("unmapped", d, 32'h0);
		wr(OFS_CHAN0, 32'h1);
		wr(OFS_CHAN1, 32'h3);
		rd(OFS_CHAN1, d);
		chk("chan1", d, 32'h3);
		wr(OFS_TIMING, 32'h0005_0040);
		wr(OFS_COMMAND, {29'h0, CMD_PRE_ALL});
		tk(40);
		chk("precharge", {16'h0, pre_cnt}, 32'h1);
		for (i = 0; i < 2; i++) begin
			wr(OFS_COMMAND, {1'b0, mrs_op[i], 13'h0, mrs_cd[i]});
			tk(40);
			chk("mrs operand", {17'h0, mrs_a}, {17'h0, mrs_op[i]});
			chk("mrs select", {28'h0, cs_seen}, {28'h0, mrs_cs[i]});
		end
		// Short period so the three start-up refreshes run quickly
		r0 = ref_cnt;
		wr(OFS_TIMING, 32'h0005_0302);
		for (i = 0; i < 300; i++) begin
			rd(OFS_TIMING, d);
			if (d[15:8] == 8'h00)
				break;
		end
		tk(10);
		chk("count end", {24'h0, d[15:8]}, 32'h0);
		chk("refreshes", {16'h0, ref_cnt - r0}, 32'h3);
		wr(OFS_TIMING, 32'h0005_0040);
		tk(40);
		access(28'h04569AB, 1'b0);
		wr(OFS_COMMAND, {29'h0, CMD_POWER_DOWN});
		tk(40);
		chk("pd cke", {31'h0, mem.cke}, 32'h0);
		rd(OFS_STATUS, d);
		chk("pd status", {31'h0, d[ST_PD_BIT]}, 32'h1);
		r0 = ref_cnt;
		tk(800);
		chk("pd refresh", {16'h0, ref_cnt}, {16'h0, r0});
		access(28'h08A5554, 1'b1);
		chk("pd wake gap", {24'h0, gap}, 32'd11);
		// Contents are gone after power-down, so start-up begins again
		wr(OFS_COMMAND, {29'h0, CMD_PRE_ALL});
		tk(40);
		chk("reinit precharge", {16'h0, pre_cnt}, 32'h2);
		wr(OFS_COMMAND, {29'h0, CMD_SELF_REF});
		tk(40);
		chk("sr entry", {30'h0, sr_ref, mem.cke}, 32'h2);
		rd(OFS_STATUS, d);
		chk("sr status", {31'h0, d[ST_SR_BIT]}, 32'h1);
		wr(OFS_COMMAND, {29'h0, CMD_NORMAL});
		tk(40);
		chk("sr exit cke", {31'h0, mem.cke}, 32'h1);
		rd(OFS_STATUS, d);
		chk("sr exit", {31'h0, d[ST_SR_BIT]}, 32'h0);
		tk(150);
		wr(OFS_TIMING, 32'h0015_0040);
		tk(40);
		chk("apd cke", {31'h0, mem.cke}, 32'h0);
		r0 = ref_cnt;
		tk(600);
		chk("apd refresh", {31'h0, ref_cnt > r0}, 32'h1);
		for (i = 0; i < 200 && mem.cke !== 1'b0; i++)
			tk(1);
		access(28'h0123456, 1'b0);
		chk("apd gap", {24'h0, gap}, 32'd1);
		close_out();
	end
endmodule : test_sdm_ctrl
